/* cpsc_cmp.sv */
// Purpose: Operand comparison for the status flags
// Assumes: Operands already fetched; size 0 byte, 1 word, 2 double
// Notes: Purely combinational
`timescale 1ns/1ps
module cpsc_cmp
  import cpsc_pkg::*;
(
  input wire cpsc_cmp_t cmp_i,
  output logic ult_o,
  output logic eq_o,
  output logic slt_o
);
  function automatic logic [32:0] ext(input logic [31:0] v, input logic [1:0] sz,
                                      input logic sgn);
    logic [32:0] r;
    r = '0;
    case (sz)
      2'h0: r = {{25{sgn & v[7]}}, v[7:0]};
      2'h1: r = {{17{sgn & v[15]}}, v[15:0]};
      default: r = {sgn & v[31], v};
    endcase
    return r;
  endfunction

  wire [32:0] u1 = ext(cmp_i.op1, cmp_i.size, 1'b0);
  wire [32:0] u2 = ext(cmp_i.op2, cmp_i.size, 1'b0);
  wire [32:0] s1 = ext(cmp_i.op1, cmp_i.size, 1'b1);
  wire [32:0] s2 = ext(cmp_i.op2, cmp_i.size, 1'b1);

  assign ult_o = cmp_i.is_float ? 1'b0 : (u2 < u1); // [RULE_03] [RULE_04]
  assign eq_o = cmp_i.is_float ? cmp_i.fp_eq : (u2 == u1); // [RULE_06]
  assign slt_o = cmp_i.is_float ? cmp_i.fp_lt : ($signed(s2) < $signed(s1)); // [RULE_07]
endmodule

/* cpsc_field_asm.sv */
// Purpose: Assembles one displacement or immediate from the extension byte stream
// Assumes: Bytes arrive most significant first, one per take
// Notes: Outputs valid in the final byte's cycle
`timescale 1ns/1ps
module cpsc_field_asm
  import cpsc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic take_i,
  input wire logic is_disp_i,
  input wire logic [2:0] imm_len_i,
  input wire logic [7:0] byte_i,
  output logic done_o,
  output logic [31:0] value_o
);
  logic [23:0] acc_q;
  logic [2:0] cnt_q;
  logic [2:0] len_q;

  // Leading bits 0x, 10, 11 give one, two or four bytes
  wire [2:0] disp_len = !byte_i[7] ? 3'h1 : (!byte_i[6] ? 3'h2 : 3'h4); // [RULE_22]
  wire first = (cnt_q == 3'h0);
  wire [2:0] len = first ? (is_disp_i ? disp_len : imm_len_i) : len_q;
  wire [31:0] whole = {acc_q, byte_i}; // [RULE_23]

  assign done_o = take_i && ((cnt_q + 3'h1) == len);

  always_comb
  begin
    value_o = whole;
    if (is_disp_i)
    begin
      case (len)
        3'h1: value_o = {{25{byte_i[6]}}, byte_i[6:0]}; // [RULE_22]
        3'h2: value_o = {{18{whole[13]}}, whole[13:0]};
        default: value_o = {{2{whole[29]}}, whole[29:0]};
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_q <= '0;
      cnt_q <= '0;
      len_q <= '0;
    end
    else if (take_i)
    begin
      acc_q <= done_o ? 24'h000000 : whole[23:0];
      cnt_q <= done_o ? 3'h0 : cnt_q + 3'h1;
      len_q <= len;
    end
  end
endmodule

/* cpsc_map.svh */
// Purpose: Field positions, reset values and encodings of the status block
// Assumes: Included by bare name from the top module and its property checker
// Notes: Definitions only
// Notes on behaviour
// RULE_01: Add carry or subtract borrow sets carry
// RULE_02: Trace flag set traps after every instruction
// RULE_03: Integer compare sets unsigned-less from operands
// RULE_04: Floating compare always clears unsigned-less
// RULE_05: General flag updated; overflow on integer arithmetic
// RULE_06: Compare sets equal flag when operands match
// RULE_07: Compare sets signed-less from two's complement
// RULE_08: User mode refuses privileged instructions
// RULE_09: High status byte writable only in supervisor
// RULE_10: Stack select chooses stack; cleared on exceptions
// RULE_11: Trace pending allows one trace per instruction
// RULE_12: Interrupt enable gates maskable, never nonmaskable
// RULE_13: Vectoring bit selects vectored interrupt handling
// RULE_14: Absent coprocessor instructions trap as undefined
// RULE_15: Four-bit configuration written only by its instruction
// RULE_16: Addresses span zero to two-to-24 minus one
// RULE_17: Word low byte at address, high next
// RULE_18: Double word low word first, any alignment
// RULE_19: Aligned double words access faster than unaligned
// RULE_20: Basic instruction holds two five-bit operand modes
// RULE_21: Scaled mode gives scale; index byte follows
// RULE_22: Displacement length from leading bits, signed value
// RULE_23: Displacements and immediates arrive most significant first
// RULE_24: Implied extensions come after addressing extensions
// RULE_25: Reserved status bits read zero, ignore writes
`ifndef CPSC_MAP_SVH
`define CPSC_MAP_SVH
// ----------------------------------------
// Status word fields
// ----------------------------------------
`define CPSC_PSW_C 0
`define CPSC_PSW_T 1
`define CPSC_PSW_L 2
`define CPSC_PSW_F 5
`define CPSC_PSW_Z 6
`define CPSC_PSW_N 7
`define CPSC_PSW_U 8
`define CPSC_PSW_S 9
`define CPSC_PSW_P 10
`define CPSC_PSW_I 11
`define CPSC_PSW_WMASK 16'h0FE7
`define CPSC_PSW_RST 16'h0000
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CPSC_CFG_I 0
`define CPSC_CFG_F 1
`define CPSC_CFG_M 2
`define CPSC_CFG_C 3
`define CPSC_CFG_RST 4'h0
// ----------------------------------------
// Memory and operand encodings
// ----------------------------------------
`define CPSC_ADDR_W 24
`define CPSC_MODE_IMM 5'h14
`define CPSC_MODE_ABS 5'h15
`define CPSC_MODE_EXT 5'h16
`define CPSC_MODE_TOS 5'h17
`define CPSC_IMPL_IMM_LEN 3'h1
`endif

/* cpsc_pkg.sv */
// Purpose: Types shared by the status block modules
// Assumes: cpsc_map.svh holds the numbers
// Notes: Structs carry grouped request signals
package cpsc_pkg;
  typedef struct packed {
    logic valid;
    logic is_float;
    logic [1:0] size;
    logic [31:0] op1;
    logic [31:0] op2;
    logic fp_eq;
    logic fp_lt;
  } cpsc_cmp_t;
  typedef struct packed {
    logic valid;
    logic carry;
    logic ovf;
  } cpsc_arith_t;
  typedef struct packed {
    logic valid;
    logic [1:0] be;
    logic [15:0] data;
  } cpsc_psw_wr_t;
  typedef struct packed {
    logic valid;
    logic priv;
    logic fpu;
    logic mmu;
    logic cust;
  } cpsc_instr_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
  } cpsc_mem_req_t;
  typedef struct packed {
    logic valid;
    logic [21:0] dword;
    logic [3:0] be_first;
    logic [3:0] be_second;
    logic split;
    logic [31:0] lanes;
  } cpsc_mem_cmd_t;
  typedef enum logic [1:0] {FK_INDEX = 2'h0, FK_DISP = 2'h1, FK_IMM = 2'h2} cpsc_fkind_t;
  typedef struct packed {
    logic valid;
    cpsc_fkind_t kind;
    logic [1:0] slot;
    logic [31:0] value;
    logic [2:0] idx_reg;
    logic [3:0] scale;
  } cpsc_field_t;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_INDEX = 2'b01, S_EXT = 2'b11, S_IMPL = 2'b10}
    cpsc_dstate_t;
endpackage

/* cpsc_top.sv */
// Purpose: Status word, configuration, memory lane steering and extension decoding
// Assumes: The core reports instruction events as one-cycle pulses on clk_sys_i
// Notes: Interrupt pins are asynchronous and pass a three-stage filter
`include "cpsc_map.svh"
`timescale 1ns/1ps
module cpsc_top
  import cpsc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire cpsc_arith_t arith_i,
  input wire cpsc_cmp_t cmp_i,
  input wire logic gen_flag_wr_i,
  input wire logic gen_flag_i,
  input wire cpsc_psw_wr_t psw_wr_i,
  output logic [15:0] psw_o,
  input wire logic cfg_wr_i,
  input wire logic [3:0] cfg_data_i,
  output logic [3:0] cfg_o,
  input wire cpsc_instr_t instr_i,
  input wire logic instr_start_i,
  input wire logic instr_end_i,
  input wire logic exc_entry_i,
  output logic trace_trap_o,
  output logic priv_trap_o,
  output logic undef_trap_o,
  output logic sp_sel_o,
  input wire logic irq_n_pin_i,
  input wire logic nmi_n_pin_i,
  output logic irq_take_o,
  output logic irq_vectored_o,
  output logic nmi_take_o,
  input wire cpsc_mem_req_t mem_req_i,
  output cpsc_mem_cmd_t mem_cmd_o,
  output logic [1:0] mem_cycles_o,
  input wire logic dec_start_i,
  input wire logic [4:0] dec_gen_a_i,
  input wire logic [4:0] dec_gen_b_i,
  input wire logic dec_two_i,
  input wire logic [2:0] dec_imm_len_i,
  input wire logic [1:0] dec_impl_disp_i,
  input wire logic dec_impl_imm_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic byte_ready_o,
  output cpsc_field_t field_o,
  output logic dec_busy_o,
  output logic dec_done_o
);
  // ----------------------------------------
  // Operand mode helpers
  // ----------------------------------------
  // {is_imm, displacement count}
  function automatic logic [2:0] ext_need(input logic [4:0] m);
    logic [2:0] r;
    r = 3'h0;
    if (m[4:3] == 2'b01)
      r = 3'h1;
    else if (m == 5'h10 || m == 5'h11 || m == 5'h12 || m == `CPSC_MODE_EXT)
      r = 3'h2;
    else if (m == `CPSC_MODE_IMM)
      r = 3'h4;
    else if (m == `CPSC_MODE_ABS || m[4:2] == 3'b110)
      r = 3'h1;
    return r;
  endfunction

  function automatic logic is_scaled(input logic [4:0] m);
    return m[4:2] == 3'b111;
  endfunction

  // ----------------------------------------
  // Status word and configuration
  // ----------------------------------------
  logic [15:0] psw_q;
  logic [15:0] psw_d;
  logic [3:0] cfg_q;
  wire user = psw_q[`CPSC_PSW_U];
  wire cmp_ult;
  wire cmp_eq;
  wire cmp_slt;

  cpsc_cmp u_cmp (
    .cmp_i(cmp_i),
    .ult_o(cmp_ult),
    .eq_o(cmp_eq),
    .slt_o(cmp_slt)
  );

  // A user program touching the high byte is refused as a whole
  wire psw_hi_refused = psw_wr_i.valid && psw_wr_i.be[1] && user; // [RULE_09]
  wire psw_wr_ok = psw_wr_i.valid && !psw_hi_refused;
  wire [15:0] psw_be_mask = {{8{psw_wr_i.be[1]}}, {8{psw_wr_i.be[0]}}};
  wire [15:0] psw_wmask = psw_be_mask & `CPSC_PSW_WMASK; // [RULE_25]
  wire cfg_refused = cfg_wr_i && user; // [RULE_08]
  wire priv_refused = instr_i.valid && instr_i.priv && user; // [RULE_08]
  wire undef_hit = instr_i.valid && ((instr_i.fpu && !cfg_q[`CPSC_CFG_F]) ||
                   (instr_i.mmu && !cfg_q[`CPSC_CFG_M]) ||
                   (instr_i.cust && !cfg_q[`CPSC_CFG_C])); // [RULE_14]

  always_comb
  begin
    psw_d = psw_q;
    if (psw_wr_ok)
      psw_d = (psw_q & ~psw_wmask) | (psw_wr_i.data & psw_wmask);
    if (arith_i.valid)
    begin
      psw_d[`CPSC_PSW_C] = arith_i.carry; // [RULE_01]
      psw_d[`CPSC_PSW_F] = arith_i.ovf; // [RULE_05]
    end
    if (gen_flag_wr_i)
      psw_d[`CPSC_PSW_F] = gen_flag_i; // [RULE_05]
    if (cmp_i.valid)
    begin
      psw_d[`CPSC_PSW_L] = cmp_ult; // [RULE_03] [RULE_04]
      psw_d[`CPSC_PSW_Z] = cmp_eq; // [RULE_06]
      psw_d[`CPSC_PSW_N] = cmp_slt; // [RULE_07]
    end
    // Pending is armed at the start so one instruction yields one trace
    if (instr_start_i)
      psw_d[`CPSC_PSW_P] = psw_q[`CPSC_PSW_T]; // [RULE_11]
    if (instr_end_i)
      psw_d[`CPSC_PSW_P] = 1'b0; // [RULE_11]
    if (exc_entry_i)
      psw_d[`CPSC_PSW_S] = 1'b0; // [RULE_10]
    psw_d = psw_d & `CPSC_PSW_WMASK; // [RULE_25]
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      psw_q <= `CPSC_PSW_RST;
      cfg_q <= `CPSC_CFG_RST;
    end
    else
    begin
      psw_q <= psw_d;
      if (cfg_wr_i && !cfg_refused)
        cfg_q <= cfg_data_i; // [RULE_15]
    end
  end

  assign psw_o = psw_q;
  assign cfg_o = cfg_q;
  assign sp_sel_o = psw_q[`CPSC_PSW_S]; // [RULE_10]

  // ----------------------------------------
  // Traps
  // ----------------------------------------
  logic trace_q;
  logic priv_q;
  logic undef_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      trace_q <= 1'b0;
      priv_q <= 1'b0;
      undef_q <= 1'b0;
    end
    else
    begin
      trace_q <= instr_end_i && psw_q[`CPSC_PSW_P]; // [RULE_02] [RULE_11]
      priv_q <= priv_refused || psw_hi_refused || cfg_refused; // [RULE_08] [RULE_09]
      undef_q <= undef_hit; // [RULE_14]
    end
  end

  assign trace_trap_o = trace_q;
  assign priv_trap_o = priv_q;
  assign undef_trap_o = undef_q;

  // ----------------------------------------
  // Interrupt pins
  // ----------------------------------------
  // A level counts once stages two and three agree
  logic [2:0] irq_sync_q;
  logic [2:0] nmi_sync_q;
  logic irq_lvl_q;
  logic nmi_lvl_q;
  logic nmi_take_q;
  wire nmi_new = (nmi_sync_q[1] == nmi_sync_q[2]) ? !nmi_sync_q[2] : nmi_lvl_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_sync_q <= 3'h7;
      nmi_sync_q <= 3'h7;
      irq_lvl_q <= 1'b0;
      nmi_lvl_q <= 1'b0;
      nmi_take_q <= 1'b0;
    end
    else
    begin
      irq_sync_q <= {irq_sync_q[1:0], irq_n_pin_i};
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_n_pin_i};
      if (irq_sync_q[1] == irq_sync_q[2])
        irq_lvl_q <= !irq_sync_q[2];
      nmi_lvl_q <= nmi_new;
      // Nonmaskable request is edge sensitive, never gated
      nmi_take_q <= nmi_new && !nmi_lvl_q; // [RULE_12]
    end
  end

  assign irq_take_o = irq_lvl_q && psw_q[`CPSC_PSW_I]; // [RULE_12]
  assign irq_vectored_o = cfg_q[`CPSC_CFG_I]; // [RULE_13]
  assign nmi_take_o = nmi_take_q;

  // ----------------------------------------
  // Memory lane steering
  // ----------------------------------------
  // Little endian: byte k of the operand goes to lane (address + k) mod 4
  wire [1:0] mem_off = mem_req_i.addr[1:0];
  wire [3:0] mem_mask = (mem_req_i.size == 2'h0) ? 4'h1 :
                        ((mem_req_i.size == 2'h1) ? 4'h3 : 4'hF); // [RULE_17] [RULE_18]
  wire [7:0] mem_span = {4'h0, mem_mask} << mem_off;
  wire [63:0] mem_dbl = {mem_req_i.wdata, mem_req_i.wdata} << {mem_off, 3'b000};
  cpsc_mem_cmd_t mem_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mem_q <= '0;
    else
    begin
      mem_q.valid <= mem_req_i.valid;
      mem_q.dword <= mem_req_i.addr[`CPSC_ADDR_W-1:2]; // [RULE_16]
      mem_q.be_first <= mem_span[3:0];
      mem_q.be_second <= mem_span[7:4];
      mem_q.split <= |mem_span[7:4]; // [RULE_19]
      mem_q.lanes <= mem_dbl[63:32];
    end
  end

  assign mem_cmd_o = mem_q;
  // Only a straddling access costs a second bus cycle
  assign mem_cycles_o = mem_q.split ? 2'h2 : 2'h1; // [RULE_19]

  // ----------------------------------------
  // Extension decoder
  // ----------------------------------------
  cpsc_dstate_t st_q;
  logic [4:0] mode_q [2];
  logic slot_q;
  logic two_q;
  logic [1:0] fcnt_q;
  logic [2:0] imm_len_q;
  logic [1:0] impl_disp_q;
  logic impl_imm_q;
  logic [2:0] idx_reg_q [2];
  logic [1:0] scale_q [2];
  cpsc_field_t field_q;
  logic done_q;

  wire [2:0] need = ext_need(mode_q[slot_q]);
  wire need_idx = is_scaled(mode_q[slot_q]); // [RULE_21]
  wire [1:0] need_cnt = need[2] ? 2'h1 : need[1:0];
  wire slot_last = slot_q || !two_q;
  wire ext_more = fcnt_q != need_cnt;
  wire impl_more = (impl_disp_q != 2'h0) || impl_imm_q;
  wire take = byte_valid_i && byte_ready_o;
  wire fld_is_disp = (st_q == S_EXT) ? !need[2] : (impl_disp_q != 2'h0);
  wire [2:0] fld_len = (st_q == S_EXT) ? imm_len_q : `CPSC_IMPL_IMM_LEN;
  wire fld_take = take && (st_q != S_INDEX);
  wire fld_done;
  wire [31:0] fld_value;

  cpsc_field_asm u_asm (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .take_i(fld_take),
    .is_disp_i(fld_is_disp),
    .imm_len_i(fld_len),
    .byte_i(byte_i),
    .done_o(fld_done),
    .value_o(fld_value)
  );

  always_comb
  begin
    unique case (st_q)
      S_INDEX: byte_ready_o = need_idx;
      S_EXT: byte_ready_o = ext_more;
      S_IMPL: byte_ready_o = impl_more;
      default: byte_ready_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q <= S_IDLE;
      mode_q <= '{default: '0};
      idx_reg_q <= '{default: '0};
      scale_q <= '{default: '0};
      slot_q <= 1'b0;
      two_q <= 1'b0;
      fcnt_q <= '0;
      imm_len_q <= '0;
      impl_disp_q <= '0;
      impl_imm_q <= 1'b0;
      field_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      field_q.valid <= 1'b0;
      done_q <= 1'b0;
      unique case (st_q)
        S_IDLE:
          if (dec_start_i)
          begin
            mode_q[0] <= dec_gen_a_i; // [RULE_20]
            mode_q[1] <= dec_gen_b_i;
            two_q <= dec_two_i;
            imm_len_q <= dec_imm_len_i; // [RULE_22]
            impl_disp_q <= dec_impl_disp_i;
            impl_imm_q <= dec_impl_imm_i;
            slot_q <= 1'b0;
            fcnt_q <= '0;
            st_q <= S_INDEX;
          end
        S_INDEX:
          // Index bytes of both operands come before any displacement
          if (!need_idx || take) // [RULE_21]
          begin
            if (need_idx)
            begin
              mode_q[slot_q] <= byte_i[7:3];
              idx_reg_q[slot_q] <= byte_i[2:0];
              scale_q[slot_q] <= mode_q[slot_q][1:0];
              field_q <= '{valid: 1'b1, kind: FK_INDEX, slot: {1'b0, slot_q},
                           value: {24'h000000, byte_i}, idx_reg: byte_i[2:0],
                           scale: 4'h1 << mode_q[slot_q][1:0]};
            end
            slot_q <= slot_last ? 1'b0 : 1'b1;
            if (slot_last)
              st_q <= S_EXT;
          end
        S_EXT:
          if (!ext_more)
          begin
            fcnt_q <= '0;
            slot_q <= slot_last ? 1'b0 : 1'b1;
            if (slot_last)
              st_q <= S_IMPL; // [RULE_24]
          end
          else if (fld_done)
          begin
            fcnt_q <= fcnt_q + 2'h1;
            field_q <= '{valid: 1'b1, kind: need[2] ? FK_IMM : FK_DISP,
                         slot: {1'b0, slot_q}, value: fld_value, idx_reg: idx_reg_q[slot_q],
                         scale: 4'h1 << scale_q[slot_q]};
          end
        S_IMPL:
          if (!impl_more)
          begin
            st_q <= S_IDLE;
            done_q <= 1'b1;
          end
          else if (fld_done)
          begin
            // Implied displacements are taken before the implied immediate
            if (impl_disp_q != 2'h0)
              impl_disp_q <= impl_disp_q - 2'h1; // [RULE_24]
            else
              impl_imm_q <= 1'b0;
            field_q <= '{valid: 1'b1, kind: (impl_disp_q != 2'h0) ? FK_DISP : FK_IMM,
                         slot: 2'h2, value: fld_value, idx_reg: 3'h0, scale: 4'h1};
          end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  assign field_o = field_q;
  assign dec_busy_o = st_q != S_IDLE;
  assign dec_done_o = done_q;
endmodule

/* cpsc_top_properties.sv */
// Purpose: Port checks of the status block
// Assumes: One clock, async low reset
// Notes: Sees only top ports
`include "cpsc_map.svh"
`timescale 1ns/1ps
module cpsc_top_properties
  import cpsc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire cpsc_arith_t arith_i,
  input wire cpsc_cmp_t cmp_i,
  input wire cpsc_psw_wr_t psw_wr_i,
  input wire logic [15:0] psw_o,
  input wire logic cfg_wr_i,
  input wire logic [3:0] cfg_o,
  input wire cpsc_instr_t instr_i,
  input wire logic instr_start_i,
  input wire logic instr_end_i,
  input wire logic exc_entry_i,
  input wire logic trace_trap_o,
  input wire logic priv_trap_o,
  input wire logic undef_trap_o,
  input wire logic sp_sel_o,
  input wire logic irq_vectored_o,
  input wire cpsc_mem_req_t mem_req_i,
  input wire cpsc_mem_cmd_t mem_cmd_o,
  input wire logic [1:0] mem_cycles_o,
  input wire logic byte_valid_i,
  input wire logic byte_ready_o,
  input wire cpsc_field_t field_o
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_int_cmp;
    cmp_i.valid && !cmp_i.is_float && cmp_i.size[1];
  endsequence
  // Start re-arms pending
  sequence s_end_pend;
    instr_end_i && psw_o[`CPSC_PSW_P] && !instr_start_i;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_carry_load: assert property (arith_i.valid |=> psw_o[0] == $past(arith_i.carry))
    else $error("carry wrong");
  a_trace_once: assert property (s_end_pend |=> trace_trap_o ##1 !trace_trap_o)
    else $error("trace not single");
  a_ult_flag: assert property (s_int_cmp |=> psw_o[2] == $past(cmp_i.op2 < cmp_i.op1))
    else $error("unsigned-less wrong");
  a_float_l_clear: assert property (cmp_i.valid && cmp_i.is_float |=> !psw_o[2])
    else $error("float left unsigned-less");
  a_cmp_equal: assert property (s_int_cmp |=> psw_o[6] == $past(cmp_i.op1 == cmp_i.op2))
    else $error("equal flag wrong");
  a_slt_flag: assert property (s_int_cmp |=> psw_o[7] == $past($signed(cmp_i.op2) < $signed(cmp_i.op1)))
    else $error("signed-less wrong");
  a_user_high_trap: assert property (psw_wr_i.valid && psw_wr_i.be[1] && psw_o[8] |=> priv_trap_o)
    else $error("user high write untrapped");
  a_exc_clears_s: assert property (exc_entry_i |=> !sp_sel_o && !psw_o[9])
    else $error("stack select kept");
  a_irq_vect: assert property (irq_vectored_o == cfg_o[`CPSC_CFG_I])
    else $error("vectoring wrong");
  a_undef_trap: assert property (instr_i.valid && instr_i.fpu && !cfg_o[1] |=> undef_trap_o)
    else $error("undefined untrapped");
  a_cfg_user: assert property (cfg_wr_i && psw_o[8] |=> priv_trap_o && cfg_o == $past(cfg_o))
    else $error("user config written");
  a_mem_dword: assert property (mem_req_i.valid |=> mem_cmd_o.dword == $past(mem_req_i.addr[23:2]))
    else $error("dword wrong");
  a_mem_cycles: assert property (mem_cycles_o == (mem_cmd_o.split ? 2'h2 : 2'h1))
    else $error("cycle count wrong");
  a_field_src: assert property (field_o.valid |-> $past(byte_valid_i && byte_ready_o))
    else $error("field without byte");
  a_psw_resv: assert property ((psw_o & ~`CPSC_PSW_WMASK) == 16'h0000)
    else $error("reserved bit set");
endmodule

/* cpsc_top_tb_top.sv */
// Purpose: Self-checking bench of the status block
// Assumes: Driven and read at the falling edge
// Notes: Implied displacements left at zero
`timescale 1ns/1ps
module cpsc_top_tb_top
  import cpsc_pkg::*;
;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, gen_flag_wr_i = 1'b0, gen_flag_i = 1'b0;
  logic cfg_wr_i = 1'b0, instr_start_i = 1'b0, instr_end_i = 1'b0, exc_entry_i = 1'b0;
  logic dec_start_i = 1'b0, dec_two_i = 1'b0, dec_impl_imm_i = 1'b0, byte_valid_i = 1'b0;
  logic irq_n_pin_i = 1'b1, nmi_n_pin_i = 1'b1;
  logic [3:0] cfg_data_i = 4'h0;
  logic [4:0] dec_gen_a_i = 5'h00, dec_gen_b_i = 5'h00;
  logic [2:0] dec_imm_len_i = 3'h1;
  logic [1:0] dec_impl_disp_i = 2'h0;
  logic [7:0] byte_i = 8'h00;
  cpsc_arith_t arith_i = '0;
  cpsc_cmp_t cmp_i = '0;
  cpsc_psw_wr_t psw_wr_i = '0;
  cpsc_instr_t instr_i = '0;
  cpsc_mem_req_t mem_req_i = '0;
  logic [15:0] psw_o;
  logic [3:0] cfg_o;
  logic trace_trap_o, priv_trap_o, undef_trap_o, sp_sel_o, irq_take_o, irq_vectored_o;
  logic nmi_take_o, byte_ready_o, dec_busy_o, dec_done_o;
  logic [1:0] mem_cycles_o;
  cpsc_mem_cmd_t mem_cmd_o;
  cpsc_field_t field_o;
  int mismatches = 0, check_count = 0;
  logic [63:0] fq[$], eq[$];
  logic [7:0] bq[$];
  cpsc_top dut (.*);
  always #25 clk_sys_i = ~clk_sys_i;
  // Unused parts of a field kind are masked
  always @(posedge clk_sys_i)
    if (field_o.valid === 1'b1)
      fq.push_back(field_o.kind == FK_INDEX ?
        {21'h0, field_o.kind, field_o.slot, 32'h0, field_o.idx_reg, field_o.scale} :
        {21'h0, field_o.kind, field_o.slot, field_o.value, 7'h0});
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test;
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick;
    @(negedge clk_sys_i);
  endtask
  task automatic pulse(ref logic s);
    tick;
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask
  task automatic wpsw(input logic [1:0] be, input logic [15:0] d);
    tick;
    psw_wr_i = '{1'b1, be, d};
    tick;
    psw_wr_i.valid = 1'b0;
  endtask
  task automatic cmpt(input logic f, input logic [31:0] a, b, input logic fe, fl, input logic [2:0] e);
    tick;
    cmp_i = '{1'b1, f, 2'h2, a, b, fe, fl};
    tick;
    cmp_i.valid = 1'b0;
    chk({psw_o[7], psw_o[6], psw_o[2]}, e);
  endtask
  task automatic instr(input logic p, fp);
    tick;
    instr_i = '{1'b1, p, fp, 1'b0, 1'b0};
    tick;
    instr_i.valid = 1'b0;
  endtask
  task automatic memt(input logic [31:0] a, input logic [1:0] s, input logic [32:0] e, input logic [31:0] ln);
    tick;
    mem_req_i = '{1'b1, a, s, 32'h11223344};
    tick;
    mem_req_i.valid = 1'b0;
    chk({mem_cmd_o.dword, mem_cmd_o.be_first, mem_cmd_o.be_second, mem_cmd_o.split, mem_cycles_o}, e);
    chk(mem_cmd_o.lanes, ln);
  endtask
  task automatic dec(input logic [4:0] a, b, input logic t, input logic [2:0] l, input logic m);
    int n;
    tick;
    {dec_start_i, dec_gen_a_i, dec_gen_b_i, dec_two_i, dec_imm_len_i, dec_impl_imm_i} = {1'b1, a, b, t, l, m};
    tick;
    dec_start_i = 1'b0;
    foreach (bq[k])
    begin
      byte_valid_i = 1'b1;
      byte_i = bq[k];
      n = 0;
      while (byte_ready_o !== 1'b1 && n < 40)
      begin
        tick;
        n++;
      end
      tick;
    end
    byte_valid_i = 1'b0;
    n = 0;
    while (dec_done_o !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    chk({dec_done_o, dec_busy_o}, 2'b10);
    chk(64'(fq.size()), 64'(eq.size()));
    foreach (eq[k])
      chk(fq[k], eq[k]);
    fq.delete();
    eq.delete();
    bq.delete();
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #100000;
    mismatches++;
    finish_test;
  end
  initial
  begin
    int n;
    repeat (20) tick;
    arst_n_i = 1'b1;
    chk({psw_o, cfg_o, mem_cycles_o}, {16'h0000, 4'h0, 2'h1});
    instr(1'b0, 1'b1);
    chk(undef_trap_o, 1);
    cfg_data_i = 4'hF;
    pulse(cfg_wr_i);
    chk({cfg_o, irq_vectored_o}, {4'hF, 1'b1});
    instr(1'b1, 1'b1);
    chk({undef_trap_o, priv_trap_o}, 0);
    wpsw(2'h3, 16'h0802);
    irq_n_pin_i = 1'b0;
    repeat (4) tick;
    chk(irq_take_o, 1);
    wpsw(2'h3, 16'h0002);
    chk(irq_take_o, 0);
    irq_n_pin_i = 1'b1;
    nmi_n_pin_i = 1'b0;
    n = 0;
    repeat (8)
    begin
      tick;
      n += int'(nmi_take_o === 1'b1);
    end
    chk(n, 1);
    nmi_n_pin_i = 1'b1;
    pulse(instr_start_i);
    chk(psw_o[10], 1);
    pulse(instr_end_i);
    chk({trace_trap_o, psw_o[10]}, 2'b10);
    pulse(instr_end_i);
    chk(trace_trap_o, 0);
    arith_i = '{1'b1, 1'b1, 1'b1};
    tick;
    chk({psw_o[5], psw_o[0]}, 2'b11);
    arith_i = '{1'b1, 1'b0, 1'b0};
    tick;
    arith_i = '0;
    chk({psw_o[5], psw_o[0]}, 2'b00);
    gen_flag_i = 1'b1;
    pulse(gen_flag_wr_i);
    chk(psw_o[5], 1);
    cmpt(1'b0, 32'h5, 32'h3, 1'b0, 1'b0, 3'b101);
    cmpt(1'b0, 32'h3, 32'hFFFFFFFF, 1'b0, 1'b0, 3'b100);
    cmpt(1'b0, 32'h7, 32'h7, 1'b0, 1'b0, 3'b010);
    cmpt(1'b0, 32'hFFFFFFFF, 32'h1, 1'b0, 1'b0, 3'b001);
    cmpt(1'b1, 32'h5, 32'h3, 1'b1, 1'b1, 3'b110);
    wpsw(2'h3, 16'hFFFF);
    chk({psw_o, sp_sel_o}, {16'h0FE7, 1'b1});
    wpsw(2'h2, 16'h0000);
    chk({priv_trap_o, psw_o}, {1'b1, 16'h0FE7});
    wpsw(2'h1, 16'h0000);
    chk(psw_o, 16'h0F00);
    cfg_data_i = 4'h0;
    pulse(cfg_wr_i);
    chk({priv_trap_o, cfg_o}, {1'b1, 4'hF});
    instr(1'b1, 1'b0);
    chk(priv_trap_o, 1);
    pulse(exc_entry_i);
    chk(sp_sel_o, 0);
    arst_n_i = 1'b0;
    repeat (2) tick;
    arst_n_i = 1'b1;
    chk({psw_o, cfg_o}, 0);
    memt(32'hAB000003, 2'h1, {22'h0, 4'h8, 4'h1, 1'b1, 2'h2}, 32'h44112233);
    memt(32'h0000040A, 2'h2, {22'h102, 4'hC, 4'h3, 1'b1, 2'h2}, 32'h33441122);
    memt(32'h00000008, 2'h2, {22'h2, 4'hF, 4'h0, 1'b0, 2'h1}, 32'h11223344);
    memt(32'h00000001, 2'h0, {22'h0, 4'h2, 4'h0, 1'b0, 2'h1}, 32'h22334411);
    bq = '{8'h05, 8'h7F, 8'hAB};
    eq = '{{21'h0, FK_INDEX, 2'h0, 32'h0, 3'h5, 4'h8}, {21'h0, FK_DISP, 2'h1, 32'hFFFFFFFF, 7'h0},
      {21'h0, FK_IMM, 2'h2, 32'h000000AB, 7'h0}};
    dec(5'h1F, 5'h08, 1'b1, 3'h1, 1'b1);
    bq = '{8'h12, 8'h34, 8'h81, 8'h23};
    eq = '{{21'h0, FK_IMM, 2'h0, 32'h00001234, 7'h0}, {21'h0, FK_DISP, 2'h1, 32'h00000123, 7'h0}};
    dec(5'h14, 5'h08, 1'b1, 3'h2, 1'b0);
    finish_test;
  end
endmodule
bind cpsc_top cpsc_top_properties u_chk (.*);
